/* include/laa_consts.svh */
// constants of the loop auto address assignment block
// assumes: included by the package and the core, nothing else
`ifndef LAA_CONSTS_SVH
`define LAA_CONSTS_SVH

`define LAA_ADDR_W        5
`define LAA_ADDR_ZERO     5'h00
`define LAA_ADDR_ONE      5'h01
`define LAA_ADDR_MAX      5'h1e
`define LAA_ADDR_ILLEGAL  5'h1f
`define LAA_SPAN_ZERO     6'h00
`define LAA_SPAN_ONE      6'h01
`define LAA_CAP_SIMPLE    0
`define LAA_CAP_EXTENDED  1
`define LAA_CAP_MULTIPLE  2
`define LAA_CAPS_DEF      3'h7
`define LAA_DFLT_AT_PON   1'b0

`endif

/* include/laa_pkg.sv */
// types of the loop auto address assignment block
// assumes: laa_consts.svh on the include path
`include "laa_consts.svh"

package laa_pkg;

  typedef logic [`LAA_ADDR_W-1:0] laa_addr_t;

  typedef enum logic [2:0] {
    MSG_SIMPLE    = 3'h0,
    MSG_EXT_PRI   = 3'h1,
    MSG_EXT_SEC   = 3'h2,
    MSG_MULTI_PRI = 3'h3,
    MSG_ZERO_SEC  = 3'h4,
    MSG_UNCONF    = 3'h5,
    MSG_GROUP     = 3'h6,
    MSG_OTHER     = 3'h7
  } laa_kind_e;

  typedef enum logic [8:0] {
    ST_UNCONF   = 9'h001,
    ST_SIMP_INC = 9'h002,
    ST_ONE_BYTE = 9'h004,
    ST_SEC_INC  = 9'h008,
    ST_WAIT_PRI = 9'h010,
    ST_PRI_INC  = 9'h020,
    ST_WAIT_SEC = 9'h040,
    ST_MULT_INC = 9'h080,
    ST_TWO_BYTE = 9'h100
  } laa_state_e;

  typedef struct packed {
    laa_kind_e  kind;
    logic [7:0] data;
  } laa_msg_s;

  typedef struct packed {
    logic      valid;
    logic      two_byte;
    logic      group;
    laa_addr_t primary;
    laa_addr_t secondary;
  } laa_query_s;

  typedef struct packed {
    logic      valid;
    laa_addr_t index;
  } laa_func_s;

endpackage : laa_pkg

/* rtl/laa_core.sv */
// loop auto address assignment state machine of one loop device
// assumes: messages arrive already decoded from the acceptor data state,
// the source handshake reports transmission start, power-on from power logic
//
// Operation
// - address sits in low five bits; values zero to thirty legal
// - all-ones address field is illegal and ignored on receipt
// - power-on leaves function unconfigured without assigned address
// - unconfigure command in any state returns to unconfigured at once
// - configured device ignores foreign addresses and further assignments
// - unconfigured: simple, secondary, multi primary start their increment states
// - simple increment stores address, forwards plus one, then one-byte configured
// - one-byte configured answers own address only, ignores group messages
// - secondary increment stores secondary, forwards plus one, then waits primary
// - wait primary takes extended primary, then two-byte configured
// - extended primary forwarded unchanged; controller advances it
// - only holders of a legal secondary accept extended primary
// - primary increment stores primary, forwards plus one, waits secondary
// - zero secondary message moves wait secondary to multiple increment
// - multiple increment numbers functions from zero, forwards next secondary
// - two-byte configured answers own pair, ignores all but unconfigure
// - device supports at least one of three capability subsets
`include "laa_consts.svh"

module laa_core
  import laa_pkg::*;
#(
  parameter logic [2:0] CAPS = `LAA_CAPS_DEF
)
(
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       power_on_i,
  input  wire logic       msg_valid_i,
  input  wire laa_msg_s   msg_i,
  input  wire logic       src_xfer_i,
  input  wire laa_addr_t  func_cnt_i,
  input  wire laa_addr_t  switch_addr_i,
  input  wire laa_query_s query_i,
  output laa_state_e      state_o,
  output logic            fwd_valid_o,
  output laa_msg_s        fwd_msg_o,
  output laa_func_s       func_assign_o,
  output logic            configured_o,
  output logic            two_byte_o,
  output logic            default_addr_o,
  output laa_addr_t       primary_o,
  output laa_addr_t       secondary_o,
  output logic [5:0]      sec_span_o,
  output logic            match_o
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic addr_legal(input laa_addr_t a);
    addr_legal = (a != `LAA_ADDR_ILLEGAL);
  endfunction : addr_legal

  // field increment
  // only the address field moves; thirty steps to the illegal code, thirty-one wraps to zero
  function automatic logic [7:0] inc_field(input logic [7:0] d);
    inc_field = {d[7:`LAA_ADDR_W], d[`LAA_ADDR_W-1:0] + `LAA_ADDR_ONE};
  endfunction : inc_field

  // ****************************************
  // switch address synchroniser
  // ****************************************
  laa_addr_t sw_meta_r;
  laa_addr_t sw_sync_r;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sw_meta_r <= `LAA_ADDR_ZERO;
      sw_sync_r <= `LAA_ADDR_ZERO;
    end
    else
    begin
      sw_meta_r <= switch_addr_i;
      sw_sync_r <= sw_meta_r;
    end
  end

  // ****************************************
  // assignment state machine
  // ****************************************
  laa_state_e state_r;
  laa_state_e state_nxt;
  laa_addr_t  pri_r;
  laa_addr_t  pri_nxt;
  laa_addr_t  sec_r;
  laa_addr_t  sec_nxt;
  logic [5:0] span_r;
  logic [5:0] span_nxt;
  logic       dflt_r;
  logic       dflt_nxt;
  logic       pend_r;
  logic       pend_nxt;
  laa_msg_s   fwd_r;
  laa_msg_s   fwd_nxt;
  laa_addr_t  cnt_r;
  laa_addr_t  cnt_nxt;
  laa_func_s  fasg_r;
  laa_func_s  fasg_nxt;
  laa_addr_t  field;
  laa_addr_t  last_idx;
  logic       take;
  logic       started;
  assign field   = msg_i.data[`LAA_ADDR_W-1:0];
  assign take    = msg_valid_i && addr_legal(field);
  assign started = pend_r && src_xfer_i;

  // a zero count still yields one function; at most thirty-one (0..30)
  always_comb
  begin
    if (func_cnt_i == `LAA_ADDR_ZERO)
      last_idx = `LAA_ADDR_ZERO;
    else if (func_cnt_i == `LAA_ADDR_ILLEGAL)
      last_idx = `LAA_ADDR_MAX;
    else
      last_idx = func_cnt_i - `LAA_ADDR_ONE;
  end

  always_comb
  begin
    state_nxt = state_r;
    pri_nxt   = pri_r;
    sec_nxt   = sec_r;
    span_nxt  = span_r;
    dflt_nxt  = dflt_r;
    pend_nxt  = pend_r;
    fwd_nxt   = fwd_r;
    cnt_nxt   = cnt_r;
    fasg_nxt  = '0;
    if (started)
      pend_nxt = 1'b0;
    if (power_on_i)
    begin
      state_nxt = ST_UNCONF;
      dflt_nxt  = `LAA_DFLT_AT_PON;
      pend_nxt  = 1'b0;
      span_nxt  = `LAA_SPAN_ZERO;
    end
    else if (msg_valid_i && msg_i.kind == MSG_UNCONF)
    begin
      state_nxt = ST_UNCONF;
      dflt_nxt  = 1'b1;
      pend_nxt  = 1'b0;
      span_nxt  = `LAA_SPAN_ZERO;
    end
    else
    begin
      case (state_r)
        ST_UNCONF:
        begin
          if (take && msg_i.kind == MSG_SIMPLE && CAPS[`LAA_CAP_SIMPLE])
          begin
            pri_nxt   = field;
            fwd_nxt   = '{kind: MSG_SIMPLE, data: inc_field(msg_i.data)};
            pend_nxt  = 1'b1;
            state_nxt = ST_SIMP_INC;
          end
          else if (take && msg_i.kind == MSG_EXT_SEC && CAPS[`LAA_CAP_EXTENDED])
          begin
            sec_nxt   = field;
            fwd_nxt   = '{kind: MSG_EXT_SEC, data: inc_field(msg_i.data)};
            pend_nxt  = 1'b1;
            state_nxt = ST_SEC_INC;
          end
          else if (take && msg_i.kind == MSG_MULTI_PRI && CAPS[`LAA_CAP_MULTIPLE])
          begin
            pri_nxt   = field;
            fwd_nxt   = '{kind: MSG_MULTI_PRI, data: inc_field(msg_i.data)};
            pend_nxt  = 1'b1;
            state_nxt = ST_PRI_INC;
          end
        end
        ST_SIMP_INC:
        begin
          if (started)
            state_nxt = ST_ONE_BYTE;
        end
        ST_SEC_INC:
        begin
          if (started)
            state_nxt = ST_WAIT_PRI;
        end
        ST_WAIT_PRI:
        begin
          if (take && msg_i.kind == MSG_EXT_PRI && addr_legal(sec_r))
          begin
            pri_nxt   = field;
            span_nxt  = `LAA_SPAN_ONE;
            fwd_nxt   = msg_i;
            pend_nxt  = 1'b1;
            state_nxt = ST_TWO_BYTE;
          end
        end
        ST_PRI_INC:
        begin
          if (started)
            state_nxt = ST_WAIT_SEC;
        end
        ST_WAIT_SEC:
        begin
          if (take && msg_i.kind == MSG_ZERO_SEC)
          begin
            sec_nxt   = `LAA_ADDR_ZERO;
            cnt_nxt   = `LAA_ADDR_ZERO;
            fwd_nxt   = msg_i;
            state_nxt = ST_MULT_INC;
          end
        end
        ST_MULT_INC:
        begin
          if (started)
            state_nxt = ST_TWO_BYTE;
          else if (!pend_r)
          begin
            fasg_nxt = '{valid: 1'b1, index: cnt_r};
            if (cnt_r == last_idx)
            begin
              // next secondary is one past the last number handed out
              fwd_nxt.kind = MSG_EXT_SEC;
              fwd_nxt.data = inc_field({fwd_r.data[7:`LAA_ADDR_W], cnt_r});
              span_nxt     = {1'b0, cnt_r} + `LAA_SPAN_ONE;
              pend_nxt     = 1'b1;
            end
            else
              cnt_nxt = cnt_r + `LAA_ADDR_ONE;
          end
        end
        ST_ONE_BYTE,
        ST_TWO_BYTE:
        begin
          state_nxt = state_r;
        end
        default:
          state_nxt = ST_UNCONF;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= ST_UNCONF;
      pri_r   <= `LAA_ADDR_ZERO;
      sec_r   <= `LAA_ADDR_ZERO;
      span_r  <= `LAA_SPAN_ZERO;
      dflt_r  <= `LAA_DFLT_AT_PON;
      pend_r  <= 1'b0;
      fwd_r   <= '0;
      cnt_r   <= `LAA_ADDR_ZERO;
      fasg_r  <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      pri_r   <= pri_nxt;
      sec_r   <= sec_nxt;
      span_r  <= span_nxt;
      dflt_r  <= dflt_nxt;
      pend_r  <= pend_nxt;
      fwd_r   <= fwd_nxt;
      cnt_r   <= cnt_nxt;
      fasg_r  <= fasg_nxt;
    end
  end

  // ****************************************
  // address recognition
  // ****************************************
  logic [5:0] sec_off;

  assign sec_off = {1'b0, query_i.secondary} - {1'b0, sec_r};

  always_comb
  begin
    match_o = 1'b0;
    case (state_r)
      ST_ONE_BYTE:
        match_o = query_i.valid && !query_i.two_byte && !query_i.group
                  && query_i.primary == pri_r;
      ST_TWO_BYTE:
        match_o = query_i.valid && query_i.two_byte && !query_i.group
                  && query_i.primary == pri_r
                  && query_i.secondary >= sec_r && sec_off < span_r;
      ST_UNCONF:
        match_o = query_i.valid && dflt_r && !query_i.two_byte
                  && !query_i.group && query_i.primary == sw_sync_r;
      default:
        match_o = 1'b0;
    endcase
  end

  // ****************************************
  // outputs
  // ****************************************
  assign state_o        = state_r;
  assign fwd_valid_o    = pend_r;
  assign fwd_msg_o      = fwd_r;
  assign func_assign_o  = fasg_r;
  assign configured_o   = (state_r == ST_ONE_BYTE) || (state_r == ST_TWO_BYTE);
  assign two_byte_o     = (state_r == ST_TWO_BYTE);
  assign default_addr_o = dflt_r && (state_r == ST_UNCONF);
  assign primary_o      = pri_r;
  assign secondary_o    = sec_r;
  assign sec_span_o     = span_r;

endmodule : laa_core

/* bench/laa_core_sva.sv */
// checker of the address assignment core ports
// assumes: bound to laa_core, laa_pkg compiled first
module laa_core_sva
  import laa_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic       power_on_i,
  input wire logic       msg_valid_i,
  input wire laa_msg_s   msg_i,
  input wire logic       src_xfer_i,
  input wire laa_state_e state_o,
  input wire logic       fwd_valid_o,
  input wire laa_msg_s   fwd_msg_o,
  input wire logic       configured_o,
  input wire logic       default_addr_o,
  input wire laa_addr_t  primary_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // assignment steps
  // ****************************************
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_take(st, k);
    state_o == st && msg_valid_i && !power_on_i && msg_i.kind == k && msg_i.data[4:0] != 5'h1f;
  endsequence
  sequence s_xfer(st);
    state_o == st && fwd_valid_o && src_xfer_i && !msg_valid_i && !power_on_i;
  endsequence
  a_unconf_cmd: assert property (msg_valid_i && !power_on_i && msg_i.kind == MSG_UNCONF
    |=> state_o == ST_UNCONF && default_addr_o && !fwd_valid_o) else $error("unconfigure missed");
  a_illegal_ignored: assert property (state_o == ST_UNCONF && msg_valid_i && !power_on_i
    && msg_i.kind != MSG_UNCONF && msg_i.data[4:0] == 5'h1f |=> state_o == ST_UNCONF) else $error("illegal taken");
  a_simple_take: assert property (s_take(ST_UNCONF, MSG_SIMPLE) |=> state_o == ST_SIMP_INC && fwd_valid_o
    && primary_o == $past(msg_i.data[4:0])
    && fwd_msg_o == {MSG_SIMPLE, $past(msg_i.data[7:5]), $past(msg_i.data[4:0]) + 5'h01}) else $error("simple take");
  a_simple_done: assert property (s_xfer(ST_SIMP_INC) |=> state_o == ST_ONE_BYTE && !fwd_valid_o)
    else $error("simple not configured");
  a_ext_primary: assert property (s_take(ST_WAIT_PRI, MSG_EXT_PRI) |=> state_o == ST_TWO_BYTE
    && primary_o == $past(msg_i.data[4:0]) && fwd_msg_o == $past(msg_i)) else $error("primary take");
  a_pri_refused: assert property (state_o == ST_UNCONF && msg_valid_i && !power_on_i
    && msg_i.kind == MSG_EXT_PRI |=> state_o == ST_UNCONF) else $error("primary without secondary");
  a_config_locked: assert property (configured_o && !fwd_valid_o && msg_valid_i && !power_on_i
    && msg_i.kind != MSG_UNCONF |=> $stable(state_o) && $stable(primary_o)) else $error("configured changed");
  a_power_on: assert property (power_on_i |=> state_o == ST_UNCONF && !default_addr_o)
    else $error("power on state");
  a_fwd_hold: assert property (fwd_valid_o && !src_xfer_i && !msg_valid_i && !power_on_i
    |=> fwd_valid_o && $stable(fwd_msg_o)) else $error("forward dropped");
  a_zero_sec: assert property (s_take(ST_WAIT_SEC, MSG_ZERO_SEC) |=> state_o == ST_MULT_INC [*2])
    else $error("zero secondary");
endmodule : laa_core_sva

bind laa_core laa_core_sva laa_core_sva_i (.mclk_i, .rst_n_i, .power_on_i, .msg_valid_i, .msg_i, .src_xfer_i,
  .state_o, .fwd_valid_o, .fwd_msg_o, .configured_o, .default_addr_o, .primary_o);

/* bench/laa_loop_peer.sv */
// next loop stage: starts retransmission of the forwarded message
// assumes: bench clock, lag chosen by the bench
module laa_loop_peer
(
  input  wire logic       mclk_i,
  input  wire logic       fwd_valid_i,
  input  wire logic [3:0] lag_i,
  output logic            xfer_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_cnt;
  initial
  begin
    xfer_o   = 1'b0;
    wait_cnt = 4'h0;
  end
  // ****************************************
  // slow neighbour
  // ****************************************
  // one pulse only: a level would start a second transfer
  always @(negedge mclk_i)
  begin
    if (xfer_o || !fwd_valid_i)
    begin
      xfer_o   <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else if (wait_cnt >= lag_i)
      xfer_o <= 1'b1;
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule : laa_loop_peer

/* bench/laa_core_tb_top.sv */
// bench of the address assignment core
// assumes: laa_loop_peer answers forwarded messages
module laa_core_tb_top
  import laa_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    laa_kind_e  k;
    logic [7:0] d;
    laa_state_e s1;
    logic       fw;
    logic [11:0] f;
    laa_state_e s2;
    logic       m;
  } laa_row_s;
  logic       mclk_i = 1'b0, rst_n_i = 1'b0, power_on_i = 1'b0, msg_valid_i = 1'b0, src_xfer_i;
  laa_msg_s   msg_i = '0;
  laa_addr_t  func_cnt_i = 5'h03, switch_addr_i = 5'h05, primary_o, secondary_o;
  laa_func_s  func_assign_o;
  logic [5:0] sec_span_o;
  logic [11:0] fa_cnt = 12'h000;
  laa_query_s query_i = '{1'b1, 1'b0, 1'b0, 5'h05, 5'h00};
  laa_state_e state_o;
  laa_msg_s   fwd_msg_o;
  logic       fwd_valid_o, configured_o, default_addr_o, match_o, two_byte_o;
  logic [3:0] lag = 4'h2;
  int         num_errors = 0, num_checks = 0;
  laa_row_s rows [14] = '{
    '{MSG_SIMPLE,   8'h05, ST_SIMP_INC, 1'b1, 12'h006, ST_ONE_BYTE, 1'b1},
    '{MSG_SIMPLE,   8'h03, ST_ONE_BYTE, 1'b0, 12'h000, ST_ONE_BYTE, 1'b1},
    '{MSG_GROUP,    8'h05, ST_ONE_BYTE, 1'b0, 12'h000, ST_ONE_BYTE, 1'b1},
    '{MSG_UNCONF,   8'h00, ST_UNCONF,   1'b0, 12'h000, ST_UNCONF,   1'b1},
    '{MSG_EXT_PRI,  8'h04, ST_UNCONF,   1'b0, 12'h000, ST_UNCONF,   1'b1},
    '{MSG_EXT_SEC,  8'he7, ST_SEC_INC,  1'b1, 12'h2e8, ST_WAIT_PRI, 1'b0},
    '{MSG_EXT_PRI,  8'h05, ST_TWO_BYTE, 1'b1, 12'h105, ST_TWO_BYTE, 1'b0},
    '{MSG_SIMPLE,   8'h02, ST_TWO_BYTE, 1'b0, 12'h000, ST_TWO_BYTE, 1'b0},
    '{MSG_UNCONF,   8'h00, ST_UNCONF,   1'b0, 12'h000, ST_UNCONF,   1'b1},
    '{MSG_MULTI_PRI, 8'h1e, ST_PRI_INC, 1'b1, 12'h31f, ST_WAIT_SEC, 1'b0},
    '{MSG_ZERO_SEC, 8'h00, ST_MULT_INC, 1'b1, 12'h203, ST_TWO_BYTE, 1'b0},
    '{MSG_UNCONF,   8'h00, ST_UNCONF,   1'b0, 12'h000, ST_UNCONF,   1'b1},
    '{MSG_SIMPLE,   8'h1f, ST_UNCONF,   1'b0, 12'h000, ST_UNCONF,   1'b1},
    '{MSG_SIMPLE,   8'h1e, ST_SIMP_INC, 1'b1, 12'h01f, ST_ONE_BYTE, 1'b0}};

  laa_core laa_core_i (.mclk_i, .rst_n_i, .power_on_i, .msg_valid_i, .msg_i, .src_xfer_i, .func_cnt_i,
    .switch_addr_i, .query_i, .state_o, .fwd_valid_o, .fwd_msg_o, .func_assign_o, .configured_o,
    .two_byte_o, .default_addr_o, .primary_o, .secondary_o, .sec_span_o, .match_o);
  laa_loop_peer laa_loop_peer_i (.mclk_i(mclk_i), .fwd_valid_i(fwd_valid_o), .lag_i(lag), .xfer_o(src_xfer_i));

  always #12.5 mclk_i = ~mclk_i;

  // function numbers handed out, counted where the pulse is settled
  always @(negedge mclk_i)
    if (func_assign_o.valid)
      fa_cnt <= fa_cnt + 12'h001;

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic send(input laa_kind_e k, input logic [7:0] d);
    @(negedge mclk_i);
    msg_i       = '{k, d};
    msg_valid_i = 1'b1;
    @(negedge mclk_i);
    msg_valid_i = 1'b0;
  endtask : send
  task automatic wait_fwd(input logic lvl);
    for (int n = 0; n < 40 && fwd_valid_o !== lvl; n++)
      @(negedge mclk_i);
  endtask : wait_fwd
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  initial
  begin
    #(25 * 5000);
    num_errors++;
    end_of_test();
  end

  initial
  begin
    repeat (12) @(negedge mclk_i);
    rst_n_i = 1'b1;
    chk("reset state", 12'(ST_UNCONF), 12'(state_o));
    chk("reset default", 12'h000, {fwd_valid_o, default_addr_o, match_o, primary_o});
    foreach (rows[i])
    begin
      send(rows[i].k, rows[i].d);
      chk("taken state", 12'(rows[i].s1), 12'(state_o));
      if (rows[i].fw)
      begin
        wait_fwd(1'b1);
        chk("forward", rows[i].f, 12'(fwd_msg_o));
      end
      wait_fwd(1'b0);
      chk("final state", 12'(rows[i].s2), 12'(state_o));
      chk("match", 12'(rows[i].m), 12'(match_o));
    end
    // late neighbour so the abort lands mid increment
    lag = 4'hf;
    send(MSG_UNCONF, 8'h00);
    send(MSG_EXT_SEC, 8'h02);
    chk("mid increment", 12'(ST_SEC_INC), 12'(state_o));
    send(MSG_UNCONF, 8'h00);
    chk("abort", {3'h3, 9'(ST_UNCONF)}, {fwd_valid_o, default_addr_o, 1'b1, 9'(state_o)});
    // two-byte setup: secondary comes back illegal, so primary zero follows
    lag = 4'h2;
    send(MSG_EXT_SEC, 8'h1e);
    wait_fwd(1'b1);
    chk("illegal return", 12'h21f, 12'(fwd_msg_o));
    wait_fwd(1'b0);
    send(MSG_EXT_PRI, 8'h00);
    wait_fwd(1'b1);
    wait_fwd(1'b0);
    chk("pair", 12'h83e, {two_byte_o, sec_span_o, secondary_o});
    query_i = '{1'b1, 1'b1, 1'b0, 5'h00, 5'h1e};
    #1;
    chk("pair match", 12'h001, 12'(match_o));
    @(negedge mclk_i);
    query_i = '{1'b1, 1'b1, 1'b0, 5'h00, 5'h1f};
    #1;
    chk("foreign pair", 12'h000, 12'(match_o));
    // extended devices are configured before the multiple sequence starts
    send(MSG_ZERO_SEC, 8'h00);
    chk("zero ignored", {3'h0, 9'(ST_TWO_BYTE)}, {fwd_valid_o, default_addr_o, 1'b0, 9'(state_o)});
    // multiple-function setup: a zero count still numbers one function
    send(MSG_UNCONF, 8'h00);
    func_cnt_i = 5'h00;
    send(MSG_MULTI_PRI, 8'h01);
    wait_fwd(1'b1);
    chk("next primary", 12'h302, 12'(fwd_msg_o));
    wait_fwd(1'b0);
    send(MSG_ZERO_SEC, 8'h00);
    wait_fwd(1'b1);
    chk("next secondary", 12'h201, 12'(fwd_msg_o));
    wait_fwd(1'b0);
    chk("multi pair", 12'h820, {two_byte_o, sec_span_o, secondary_o});
    query_i = '{1'b1, 1'b1, 1'b0, 5'h01, 5'h00};
    #1;
    chk("multi match", 12'h001, 12'(match_o));
    chk("functions", 12'h004, fa_cnt);
    // reset in mid-run drops the assignment
    @(negedge mclk_i);
    rst_n_i = 1'b0;
    @(negedge mclk_i);
    rst_n_i = 1'b1;
    chk("mid reset", {3'h0, 9'(ST_UNCONF)}, {fwd_valid_o, default_addr_o, configured_o, 9'(state_o)});
    send(MSG_SIMPLE, 8'h01);
    @(negedge mclk_i);
    power_on_i = 1'b1;
    @(negedge mclk_i);
    power_on_i = 1'b0;
    chk("power on", {3'h0, 9'(ST_UNCONF)}, {fwd_valid_o, default_addr_o, match_o, 9'(state_o)});
    end_of_test();
  end
endmodule : laa_core_tb_top
